/* sdr_servo_ctrl.sv */
// servo mode, motor switch, servo inhibit and emergency retract control
// assumes pins are asynchronous to clk_sys and software uses axi4-lite
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps

// counts how long a condition has held; restarts whenever it clears
module sdr_qual_timer #(
    parameter logic [31:0] CYCLES = 32'h0000_0010
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic cond,
    output logic done
);
    logic [31:0] count_q;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            count_q <= 32'h0000_0000;
        end else if (!cond) begin
            count_q <= 32'h0000_0000;
        end else if (count_q != CYCLES) begin
            count_q <= count_q + 32'h0000_0001;
        end
    end

    assign done = cond && (count_q == CYCLES);
endmodule : sdr_qual_timer

module sdr_servo_ctrl #(
    parameter logic [31:0] QUAL_CYCLES = sdr_pkg::QUAL_CYCLES,
    parameter logic [31:0] POR_CYCLES = sdr_pkg::POR_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire sdr_pkg::sdr_pins_t pins,
    output logic velocity_loop_enable,
    output logic velocity_amp_on,
    output logic ref_ground_sw,
    output logic motor_pos_sw,
    output logic motor_neg_sw,
    output logic servo_inhibit_n,
    output logic emergency_retract,
    output logic retract_relay_energize,
    output logic irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int PW = sdr_pkg::PINS_W;
    localparam int EW = sdr_pkg::EV_W;

    // pin synchroniser, stage one read only by stage two
    logic [PW-1:0] sync1_q;
    logic [PW-1:0] sync2_q;
    logic [PW-1:0] sync3_q;
    logic [PW-1:0] pin_q;
    sdr_pkg::sdr_pins_t p;

    // register and state
    logic [7:0] ctrl_q;
    logic [EW-1:0] irq_stat_q;
    logic [EW-1:0] irq_mask_q;
    logic vel_en_q;
    logic run_en_q;
    logic clamp_rel_q;
    logic latch_q;
    logic retract_q;
    logic inhibit_q;
    logic servo_enabled_q;
    logic pos_sw_q;
    logic neg_sw_q;
    logic relay_q;
    logic ref_sw_q;

    // bus state
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // derived conditions
    logic wr_do;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;
    logic seek_go;
    logic detent;
    logic neg18_lost;
    logic amp50_fail;
    logic por_done;
    logic unsafe_now;
    logic latch_set;
    logic latch_clr;
    logic retract_cause;
    logic inhibit_cause;
    logic [EW-1:0] events;
    logic [EW-1:0] rd_ev_prev_q;
    logic [EW-1:0] ev_level;
    logic [31:0] status_word;

    // three-stage synchroniser; a change counts once stages two and three agree
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // per-bit filter: take the new level only when both late stages agree
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pin_q <= '0;
        end else begin
            for (int i = 0; i < PW; i++) begin
                if (sync2_q[i] == sync3_q[i]) begin
                    pin_q[i] <= sync3_q[i];
                end
            end
        end
    end

    assign p = pin_q;

    sdr_qual_timer #(.CYCLES(QUAL_CYCLES)) u_neg18 (
        .clk_sys(clk_sys),
        .reset(reset),
        .cond(!p.neg18_ok),
        .done(neg18_lost)
    );

    sdr_qual_timer #(.CYCLES(QUAL_CYCLES)) u_amp50 (
        .clk_sys(clk_sys),
        .reset(reset),
        .cond(!p.pos50_ok || !p.neg50_ok),
        .done(amp50_fail)
    );

    // power-on clamp delay counts from reset release
    sdr_qual_timer #(.CYCLES(POR_CYCLES)) u_por (
        .clk_sys(clk_sys),
        .reset(reset),
        .cond(1'b1),
        .done(por_done)
    );

    // bus write decode
    assign wr_do = aw_have_q && w_have_q && !bvalid_q && wstrb_q[0];
    assign wr_ctrl = wr_do && (waddr_q == sdr_pkg::REG_CTRL);
    assign wr_stat = wr_do && (waddr_q == sdr_pkg::REG_IRQ_STAT);
    assign wr_mask = wr_do && (waddr_q == sdr_pkg::REG_IRQ_MASK);
    assign seek_go = wr_ctrl && wdata_q[sdr_pkg::CTRL_SEEK_GO];
    assign detent = wr_ctrl && wdata_q[sdr_pkg::CTRL_DETENT];

    // control register; command bits are pulses and do not stay stored
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctrl_q <= sdr_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= {5'h00, wdata_q[sdr_pkg::CTRL_OFFSET_DIR], 2'h0};
        end
    end

    // clamp releases after delay only while supply is present
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            clamp_rel_q <= 1'b0;
        end else begin
            clamp_rel_q <= por_done && p.neg18_ok;
        end
    end

    // run enable raised by any seek while the clamp is released
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            run_en_q <= 1'b0;
        end else if (seek_go && clamp_rel_q) begin
            run_en_q <= 1'b1;
        end else if (!clamp_rel_q || p.maint_disable || !p.sequence_up) begin
            run_en_q <= 1'b0;
        end
    end

    // servo under control, used to judge unsafe current
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            servo_enabled_q <= 1'b0;
        end else begin
            servo_enabled_q <= run_en_q && clamp_rel_q && !p.maint_disable;
        end
    end

    assign latch_set = p.offtrack || (p.seek_enable_cmd && !p.heads_loaded);
    assign latch_clr = !p.sequence_up || !p.run_switch || p.maint_disable;

    // retract latch; a set in the clearing cycle wins
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            latch_q <= 1'b0;
        end else if (latch_set) begin
            latch_q <= 1'b1;
        end else if (latch_clr) begin
            latch_q <= 1'b0;
        end
    end

    // unsafe current with servo not enabled
    assign unsafe_now = p.power_amp_unsafe && !servo_enabled_q;
    // any retract cause, amplifier supply qualified
    assign retract_cause = amp50_fail || !p.dc_ok || latch_q || unsafe_now;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            retract_q <= 1'b0;
        end else begin
            retract_q <= retract_cause;
        end
    end

    assign inhibit_cause = p.maint_disable || (retract_q && !p.maint_disable)
        || neg18_lost || !clamp_rel_q || !run_en_q;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            inhibit_q <= 1'b1;
        end else begin
            inhibit_q <= inhibit_cause;
        end
    end

    // velocity loop enable: seek start raises, detent drops
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            vel_en_q <= 1'b0;
        end else if (seek_go && clamp_rel_q) begin
            vel_en_q <= 1'b1;
        end else if (detent || retract_q || inhibit_cause) begin
            vel_en_q <= 1'b0;
        end
    end

    // motor switches exclusive, off while inhibited or retracting
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pos_sw_q <= 1'b0;
            neg_sw_q <= 1'b0;
        end else begin
            pos_sw_q <= p.drive_pos && !p.drive_neg && !inhibit_cause && !retract_cause;
            neg_sw_q <= p.drive_neg && !p.drive_pos && !inhibit_cause && !retract_cause;
        end
    end

    // relay drops out during retract; grounding switch follows offset
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            relay_q <= 1'b0;
            ref_sw_q <= 1'b0;
        end else begin
            relay_q <= !retract_cause;
            ref_sw_q <= ctrl_q[sdr_pkg::CTRL_OFFSET_DIR];
        end
    end

    assign velocity_loop_enable = vel_en_q;
    assign velocity_amp_on = vel_en_q && !inhibit_q;
    assign ref_ground_sw = ref_sw_q;
    assign motor_pos_sw = pos_sw_q;
    assign motor_neg_sw = neg_sw_q;
    assign servo_inhibit_n = !inhibit_q;
    assign emergency_retract = retract_q;
    assign retract_relay_energize = relay_q;

    // event levels; rising edges set sticky bits
    assign ev_level = {unsafe_now, amp50_fail, neg18_lost, inhibit_q, retract_q};
    assign events = ev_level & ~rd_ev_prev_q;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rd_ev_prev_q <= '0;
        end else begin
            rd_ev_prev_q <= ev_level;
        end
    end

    // sticky status, write one to clear, new event wins over clear
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            irq_stat_q <= '0;
        end else if (wr_stat) begin
            irq_stat_q <= (irq_stat_q & ~wdata_q[EW-1:0]) | events;
        end else begin
            irq_stat_q <= irq_stat_q | events;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            irq_mask_q <= sdr_pkg::IRQ_MASK_RESET;
        end else if (wr_mask) begin
            irq_mask_q <= wdata_q[EW-1:0];
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // live state for the status register
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[sdr_pkg::ST_VEL_EN] = vel_en_q;
        status_word[sdr_pkg::ST_RUN_EN] = run_en_q;
        status_word[sdr_pkg::ST_CLAMP_REL] = clamp_rel_q;
        status_word[sdr_pkg::ST_INHIBIT] = inhibit_q;
        status_word[sdr_pkg::ST_RETRACT] = retract_q;
        status_word[sdr_pkg::ST_LATCH] = latch_q;
        status_word[sdr_pkg::ST_NEG18_LOST] = neg18_lost;
        status_word[sdr_pkg::ST_AMP50_FAIL] = amp50_fail;
    end

    // write channels: address and data taken in either order
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            waddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                waddr_q <= s_axi_awaddr;
            end else if (bvalid_q && s_axi_bready) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (bvalid_q && s_axi_bready) begin
                w_have_q <= 1'b0;
            end
        end
    end

    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready = !w_have_q;

    // write response once both halves are held
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            bvalid_q <= 1'b0;
            bresp_q <= sdr_pkg::RESP_OKAY;
        end else if (aw_have_q && w_have_q && !bvalid_q) begin
            bvalid_q <= 1'b1;
            bresp_q <= (waddr_q == sdr_pkg::REG_CTRL || waddr_q == sdr_pkg::REG_STATUS
                || waddr_q == sdr_pkg::REG_IRQ_STAT || waddr_q == sdr_pkg::REG_IRQ_MASK)
                ? sdr_pkg::RESP_OKAY : sdr_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // read channel: data one cycle after the address is taken
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= sdr_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= sdr_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                sdr_pkg::REG_CTRL: rdata_q <= {24'h000000, ctrl_q};
                sdr_pkg::REG_STATUS: rdata_q <= status_word;
                sdr_pkg::REG_IRQ_STAT: rdata_q <= {27'h0, irq_stat_q};
                sdr_pkg::REG_IRQ_MASK: rdata_q <= {27'h0, irq_mask_q};
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= sdr_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule : sdr_servo_ctrl

/* sdr_pkg.sv */
// package for the servo disable and emergency retract control block
// assumes a single 250 MHz system clock and an axi4-lite register bus
package sdr_pkg;

    // clock rate and second-scale qualification times
    localparam int unsigned CLK_KHZ = 250_000;
    localparam int unsigned QUAL_MS = 2000;      // supply failure qualification
    localparam int unsigned POR_MS = 1000;       // power-on clamp delay
    localparam logic [31:0] QUAL_CYCLES = 32'(QUAL_MS * CLK_KHZ);
    localparam logic [31:0] POR_CYCLES = 32'(POR_MS * CLK_KHZ);

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;

    // control register fields
    localparam int CTRL_SEEK_GO = 0;     // write one: start a seek
    localparam int CTRL_DETENT = 1;      // write one: heads detented on track
    localparam int CTRL_OFFSET_DIR = 2;  // level: high selects reverse offset
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // status register fields
    localparam int ST_VEL_EN = 0;
    localparam int ST_RUN_EN = 1;
    localparam int ST_CLAMP_REL = 2;
    localparam int ST_INHIBIT = 3;
    localparam int ST_RETRACT = 4;
    localparam int ST_LATCH = 5;
    localparam int ST_NEG18_LOST = 6;
    localparam int ST_AMP50_FAIL = 7;

    // interrupt event bits, same layout in status and mask
    localparam int EV_RETRACT = 0;
    localparam int EV_INHIBIT = 1;
    localparam int EV_NEG18_LOST = 2;
    localparam int EV_AMP50_FAIL = 3;
    localparam int EV_UNSAFE = 4;
    localparam int EV_W = 5;
    localparam logic [EV_W-1:0] IRQ_MASK_RESET = 5'h00;

    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // pins arriving from switches, supplies, amplifier and controller
    typedef struct packed {
        logic maint_disable;     // maintenance switch in disable position
        logic run_switch;        // start/stop switch at start
        logic sequence_up;       // controller sequence line
        logic seek_enable_cmd;   // seek-enable command from controller
        logic neg18_ok;          // retraction supply present
        logic pos50_ok;          // amplifier positive supply good
        logic neg50_ok;          // amplifier negative supply good
        logic dc_ok;             // all dc operating voltages good
        logic offtrack;          // end-stop switch closed
        logic heads_loaded;      // heads flying over the pack
        logic power_amp_unsafe;  // monitor sees uncontrolled motor current
        logic drive_pos;         // amplifier drive level above positive threshold
        logic drive_neg;         // amplifier drive level below negative threshold
    } sdr_pins_t;

    localparam int PINS_W = $bits(sdr_pins_t);

endpackage : sdr_pkg

/* sdr_servo_monitor.sv */
// checker for the servo disable and emergency retract block
// assumes it is bound to sdr_servo_ctrl and sees only its ports
`timescale 1ns/10ps
module sdr_servo_monitor #(
    parameter logic [31:0] POR_CYCLES = 32'h0000_000A
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire sdr_pkg::sdr_pins_t pins,
    input wire logic velocity_loop_enable,
    input wire logic velocity_amp_on,
    input wire logic motor_pos_sw,
    input wire logic motor_neg_sw,
    input wire logic servo_inhibit_n,
    input wire logic emergency_retract,
    input wire logic retract_relay_energize,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic [31:0] up_q;

    // cycles since reset release, saturating
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            up_q <= 32'h0000_0000;
        end else if (up_q != 32'hFFFF_FFFF) begin
            up_q <= up_q + 32'h0000_0001;
        end
    end

    a_motor_exclusive: assert property (!(motor_pos_sw && motor_neg_sw))
        else $error("both motor current switches on");
    a_amp_gated: assert property (velocity_amp_on |-> velocity_loop_enable && servo_inhibit_n)
        else $error("velocity amp on without loop enable");
    a_maint_inhibit: assert property (pins.maint_disable [*7] |-> !servo_inhibit_n)
        else $error("maintenance disable did not inhibit");
    a_retract_inhibit: assert property (emergency_retract |=> !servo_inhibit_n)
        else $error("retract without servo inhibit");
    a_retract_relay: assert property (emergency_retract |-> !retract_relay_energize)
        else $error("relay energized during retract");
    a_offtrack_retract: assert property (pins.offtrack [*8] |-> emergency_retract)
        else $error("end stop did not retract");
    a_dc_retract: assert property (!pins.dc_ok [*8] |-> emergency_retract)
        else $error("dc failure did not retract");
    a_unsafe_retract: assert property ((pins.power_amp_unsafe && !servo_inhibit_n) [*8]
        |-> emergency_retract)
        else $error("unsafe current did not retract");
    a_por_clamp: assert property (up_q < POR_CYCLES |-> !servo_inhibit_n)
        else $error("servo enabled before clamp delay");

    // main scenarios reached
    c_retract: cover property (emergency_retract);
    c_amp_on: cover property (velocity_amp_on);
    c_irq: cover property (irq);
endmodule : sdr_servo_monitor

bind sdr_servo_ctrl sdr_servo_monitor #(.POR_CYCLES(POR_CYCLES)) u_mon (.clk_sys, .reset,
    .pins, .velocity_loop_enable, .velocity_amp_on, .motor_pos_sw, .motor_neg_sw,
    .servo_inhibit_n, .emergency_retract, .retract_relay_energize, .irq);

/* sdr_amp_model.sv */
// servo drive amplifier model: amplifier output level against its thresholds
// assumes swing is driven by the bench: 1 positive, 2 negative, else null
`timescale 1ns/10ps
module sdr_amp_model (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [1:0] swing,
    output logic drive_pos,
    output logic drive_neg
);
    // one level at a time, as a real output cannot be both above and below
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            drive_pos <= 1'b0;
            drive_neg <= 1'b0;
        end else begin
            drive_pos <= (swing == 2'h1);
            drive_neg <= (swing == 2'h2);
        end
    end
endmodule : sdr_amp_model

/* tb_top.sv */
// self-checking bench for sdr_servo_ctrl over axi4-lite and pin levels
// assumes shortened qualification and clamp counts, amplifier model on drive levels
`timescale 1ns/10ps
module tb_top;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    sdr_pkg::sdr_pins_t pn = 13'h0DE8;
    sdr_pkg::sdr_pins_t pins;
    logic [1:0] swing = 2'h0;
    logic m_pos, m_neg, vle, vao, rgs, mps, mns, sin, ert, rre, irq;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd;
    int n_errors = 0;
    int comparisons = 0;
    int i;

    // clock and pin merge with amplifier levels
    always #2 clk_sys = ~clk_sys;
    always_comb begin
        pins = pn;
        pins.drive_pos = m_pos;
        pins.drive_neg = m_neg;
    end

    sdr_amp_model u_amp (.clk_sys(clk_sys), .reset(reset), .swing(swing),
        .drive_pos(m_pos), .drive_neg(m_neg));
    sdr_servo_ctrl #(.QUAL_CYCLES(32'h0000_0014), .POR_CYCLES(32'h0000_000A)) dut (
        .clk_sys(clk_sys), .reset(reset), .pins(pins), .velocity_loop_enable(vle),
        .velocity_amp_on(vao), .ref_ground_sw(rgs), .motor_pos_sw(mps), .motor_neg_sw(mns),
        .servo_inhibit_n(sin), .emergency_retract(ert), .retract_relay_energize(rre),
        .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    task automatic tally_and_finish();
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    // wait edges, then settle at the falling edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : cyc

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // axi write: ready sampled at the falling edge, released after the taking edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        int n;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge clk_sys);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            r = bresp;
            @(posedge clk_sys);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) break;
        end
        bready <= 1'b0;
        if (n == 50) n_errors++;
    endtask : wr

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        int n;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(negedge clk_sys);
            ta = arvalid && arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk_sys);
            if (ta) arvalid <= 1'b0;
            if (tr) break;
        end
        rready <= 1'b0;
        if (n == 50) n_errors++;
    endtask : rd_reg

    task automatic wok(input logic [7:0] a, input logic [31:0] d);
        wr(a, d, rs);
        chk("bresp", 32'(sdr_pkg::RESP_OKAY), 32'(rs));
    endtask : wok

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rd_reg(a, rd, rs);
        chk($sformatf("reg %h", a), exp, rd);
    endtask : rchk

    // hang guard
    initial begin
        #40000;
        n_errors++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        cyc(1);
        chk("inhibit_n", 32'h0, sin);
        rchk(sdr_pkg::REG_IRQ_MASK, 32'h0000_0000);
        rchk(sdr_pkg::REG_STATUS, 32'h0000_0008);
        cyc(20);
        rchk(sdr_pkg::REG_STATUS, 32'h0000_000C);
        chk("inhibit_n", 32'h0, sin);
        wok(sdr_pkg::REG_CTRL, 32'h0000_0001);
        cyc(4);
        chk("vel_loop_en", 32'h1, vle);
        chk("vel_amp_on", 32'h1, vao);
        chk("inhibit_n", 32'h1, sin);
        wok(sdr_pkg::REG_CTRL, 32'h0000_0002);
        cyc(2);
        chk("vel_loop_en", 32'h0, vle);
        chk("vel_amp_on", 32'h0, vao);
        wok(sdr_pkg::REG_CTRL, 32'h0000_0004);
        cyc(2);
        chk("ref_ground", 32'h1, rgs);
        rchk(sdr_pkg::REG_CTRL, 32'h0000_0004);
        wok(sdr_pkg::REG_CTRL, 32'h0000_0000);
        cyc(2);
        chk("ref_ground", 32'h0, rgs);
        for (i = 1; i < 3; i++) begin
            @(posedge clk_sys);
            swing <= 2'(i);
            cyc(8);
            chk("motor_pos", 32'(i == 1), mps);
            chk("motor_neg", 32'(i == 2), mns);
        end
        @(posedge clk_sys);
        swing <= 2'h0;
        wr(8'h20, 32'h0000_0001, rs);
        chk("bresp unmapped", 32'(sdr_pkg::RESP_SLVERR), 32'(rs));
        rd_reg(8'h10, rd, rs);
        chk("rresp unmapped", 32'(sdr_pkg::RESP_SLVERR), 32'(rs));
        chk("rdata unmapped", 32'h0, rd);
        wok(sdr_pkg::REG_IRQ_MASK, 32'h0000_001F);
        @(posedge clk_sys);
        pn.pos50_ok <= 1'b0;
        repeat (16) @(posedge clk_sys);
        pn.pos50_ok <= 1'b1;
        cyc(10);
        chk("retract short fail", 32'h0, ert);
        @(posedge clk_sys);
        pn.neg50_ok <= 1'b0;
        cyc(12);
        chk("retract restart", 32'h0, ert);
        cyc(18);
        chk("retract", 32'h1, ert);
        chk("relay", 32'h0, rre);
        chk("inhibit_n", 32'h0, sin);
        chk("irq", 32'h1, irq);
        rchk(sdr_pkg::REG_STATUS, 32'h0000_009E);
        pn.neg50_ok <= 1'b1;
        cyc(10);
        rchk(sdr_pkg::REG_IRQ_STAT, 32'h0000_000B);
        wok(sdr_pkg::REG_IRQ_STAT, 32'h0000_000B);
        rchk(sdr_pkg::REG_IRQ_STAT, 32'h0000_0000);
        chk("irq cleared", 32'h0, irq);
        wok(sdr_pkg::REG_IRQ_MASK, 32'h0000_0000);
        wok(sdr_pkg::REG_CTRL, 32'h0000_0001);
        pn.power_amp_unsafe <= 1'b1;
        cyc(10);
        chk("retract enabled", 32'h0, ert);
        @(posedge clk_sys);
        pn.maint_disable <= 1'b1;
        cyc(12);
        chk("inhibit_n maint", 32'h0, sin);
        chk("retract unsafe", 32'h1, ert);
        chk("irq masked", 32'h0, irq);
        rchk(sdr_pkg::REG_IRQ_STAT, 32'h0000_0013);
        pn.power_amp_unsafe <= 1'b0;
        pn.maint_disable <= 1'b0;
        cyc(8);
        wok(sdr_pkg::REG_CTRL, 32'h0000_0001);
        for (i = 0; i < 3; i++) begin
            @(posedge clk_sys);
            pn.offtrack <= (i != 1);
            pn.seek_enable_cmd <= (i == 1);
            pn.heads_loaded <= (i != 1);
            repeat (6) @(posedge clk_sys);
            pn.offtrack <= 1'b0;
            pn.seek_enable_cmd <= 1'b0;
            pn.heads_loaded <= 1'b1;
            cyc(8);
            chk("retract latched", 32'h1, ert);
            chk("relay", 32'h0, rre);
            @(posedge clk_sys);
            pn.sequence_up <= (i != 0);
            pn.run_switch <= (i != 1);
            pn.maint_disable <= (i == 2);
            repeat (6) @(posedge clk_sys);
            pn.sequence_up <= 1'b1;
            pn.run_switch <= 1'b1;
            pn.maint_disable <= 1'b0;
            cyc(8);
            chk("retract cleared", 32'h0, ert);
        end
        @(posedge clk_sys);
        pn.dc_ok <= 1'b0;
        cyc(8);
        chk("retract dc", 32'h1, ert);
        @(posedge clk_sys);
        pn.dc_ok <= 1'b1;
        pn.neg18_ok <= 1'b0;
        cyc(30);
        chk("inhibit_n supply", 32'h0, sin);
        rd_reg(sdr_pkg::REG_STATUS, rd, rs);
        chk("neg18 lost", 32'h1, 32'(rd[6]));
        tally_and_finish();
    end
endmodule : tb_top
